// File: hw/cpwr_map.vh
// Register map, field positions and reset values of the codec power registers
// How it works
// - Any write to the word at index zero resets every register to its default.
// - Reading the word at index zero returns the part identifier, not written data.
// - Bit 8 of power_enable_one turns on the independent bias generator, reset 0.
// - Bit 7 of power_enable_one enables the level shifters when 1, standby when 0, reset 0.
// - Bit 5 of power_enable_one switches the PLL on when 1, off after reset.
// - Bit 4 of power_enable_one enables microphone bias, else high impedance, reset 0.
// - Bit 3 of power_enable_one enables the amplifier bias when 1, reset disabled.
// - Reads of bits 2:0 of power_enable_one return the silicon revision.
// - Bit 2 enables the reference buffer; when 0 analogue pins settle to ground.
// - Bits 1:0 pick the divider: 00 open, 01 50k, 10 250k, 11 5k; reset 00.
// - Bit 2 of power_enable_two enables the input gain amplifier, reset disabled.
`ifndef CPWR_MAP_VH
`define CPWR_MAP_VH

// Register indices and byte addresses
`define CPWR_IDX_RESET_ID 2'h0
`define CPWR_IDX_POWER_ONE 2'h1
`define CPWR_IDX_POWER_TWO 2'h2
`define CPWR_IDX_STATUS 2'h3
`define CPWR_WORD_LSB 2

// Field positions in power_enable_one
`define CPWR_P1_INDEP_BIAS 8
`define CPWR_P1_LEVEL_SHIFT 7
`define CPWR_P1_AUX_BUF 6
`define CPWR_P1_PLL 5
`define CPWR_P1_MIC_BIAS 4
`define CPWR_P1_AMP_BIAS 3
`define CPWR_P1_REF_BUF 2
`define CPWR_P1_IMP_HI 1
`define CPWR_P1_IMP_LO 0

// Field positions in power_enable_two
`define CPWR_P2_BOOST 4
`define CPWR_P2_GAIN_AMP 2
`define CPWR_P2_CONV_IN 0

// Reset values; the identity value is arbitrary
`define CPWR_RST_BIT 1'b0
`define CPWR_RST_IMP 2'h0
`define CPWR_PART_ID 16'hC0DE
`define CPWR_REVISION 3'h0

// Bus answers
`define CPWR_RESP_OKAY 2'h0
`define CPWR_RESP_SLVERR 2'h2
`define CPWR_ZERO_WORD 32'h00000000

`endif

// File: hw/cpwr_regs.v
// AXI4-Lite register bank for codec power management
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "cpwr_map.vh"

module cpwr_regs #(
    parameter ADDR_W = 4,
    // Arbitrary identifier value returned at index zero
    parameter [15:0] PART_ID = `CPWR_PART_ID,
    parameter [2:0] REVISION = `CPWR_REVISION
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Write address channel
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // Write data channel
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // Write response channel
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // Read address channel
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // Read data channel
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Power enables to the analogue blocks
    output reg independent_bias_enable,
    output reg level_shifter_enable,
    output reg aux_input_buffer_enable,
    output reg pll_power_enable,
    output reg mic_bias_enable,
    output reg amp_bias_enable,
    output reg reference_buffer_enable,
    output reg [1:0] reference_impedance_select,
    output reg input_boost_enable,
    output reg input_gain_amp_enable,
    output reg converter_in_enable
);

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Word index of a byte address, with a valid flag in the top bit
    function [2:0] word_index;
        input [ADDR_W-1:0] addr;
        reg [ADDR_W-1:0] word;
        begin
            word = addr >> `CPWR_WORD_LSB;
            if (word == {{(ADDR_W-2){1'b0}}, `CPWR_IDX_RESET_ID}) begin
                word_index = {1'b1, `CPWR_IDX_RESET_ID};
            end else if (word == {{(ADDR_W-2){1'b0}}, `CPWR_IDX_POWER_ONE}) begin
                word_index = {1'b1, `CPWR_IDX_POWER_ONE};
            end else if (word == {{(ADDR_W-2){1'b0}}, `CPWR_IDX_POWER_TWO}) begin
                word_index = {1'b1, `CPWR_IDX_POWER_TWO};
            end else if (word == {{(ADDR_W-2){1'b0}}, `CPWR_IDX_STATUS}) begin
                word_index = {1'b1, `CPWR_IDX_STATUS};
            end else begin
                word_index = {1'b0, `CPWR_IDX_RESET_ID};
            end
        end
    endfunction

    // Merge one bit of write data under its byte strobe
    function lane_bit;
        input old_bit;
        input [31:0] data;
        input [3:0] strb;
        input integer pos;
        begin
            if (strb[pos / 8]) begin
                lane_bit = data[pos];
            end else begin
                lane_bit = old_bit;
            end
        end
    endfunction

    // Bus answer for a decoded word index
    function [1:0] word_resp;
        input [2:0] index;
        begin
            if (index[2]) begin
                word_resp = `CPWR_RESP_OKAY;
            end else begin
                word_resp = `CPWR_RESP_SLVERR;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Write channel state

    reg [ADDR_W-1:0] wr_addr;
    reg [31:0] wr_data;
    reg [3:0] wr_strb;
    reg next_awready;
    reg next_wready;
    reg next_bvalid;
    reg [1:0] next_bresp;
    reg [ADDR_W-1:0] next_wr_addr;
    reg [31:0] next_wr_data;
    reg [3:0] next_wr_strb;
    wire [2:0] wr_index;
    wire wr_go;
    wire wr_soft_reset;

    // Both halves held and no answer outstanding
    assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_index = word_index(wr_addr);
    assign wr_soft_reset = wr_go && (wr_index == {1'b1, `CPWR_IDX_RESET_ID});

    // Address and data taken in either order, answer once both are held
    always @* begin
        next_awready = s_axi_awready;
        next_wready = s_axi_wready;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        next_wr_strb = wr_strb;
        if (s_axi_awvalid && s_axi_awready) begin
            next_wr_addr = s_axi_awaddr;
            next_awready = 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_wr_data = s_axi_wdata;
            next_wr_strb = s_axi_wstrb;
            next_wready = 1'b0;
        end
        if (wr_go) begin
            next_bvalid = 1'b1;
            next_bresp = word_resp(wr_index);
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
            next_awready = 1'b1;
            next_wready = 1'b1;
        end
    end

    // Write channel registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CPWR_RESP_OKAY;
            wr_addr <= {ADDR_W{1'b0}};
            wr_data <= `CPWR_ZERO_WORD;
            wr_strb <= 4'h0;
        end else begin
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
            wr_strb <= next_wr_strb;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power enable registers

    wire wr_one;
    wire wr_two;
    reg next_independent_bias_enable;
    reg next_level_shifter_enable;
    reg next_aux_input_buffer_enable;
    reg next_pll_power_enable;
    reg next_mic_bias_enable;
    reg next_amp_bias_enable;
    reg next_reference_buffer_enable;
    reg [1:0] next_reference_impedance_select;
    reg next_input_boost_enable;
    reg next_input_gain_amp_enable;
    reg next_converter_in_enable;

    assign wr_one = wr_go && (wr_index == {1'b1, `CPWR_IDX_POWER_ONE});
    assign wr_two = wr_go && (wr_index == {1'b1, `CPWR_IDX_POWER_TWO});

    // Every enable holds unless a soft reset or its own word arrives
    always @* begin
        next_independent_bias_enable = independent_bias_enable;
        next_level_shifter_enable = level_shifter_enable;
        next_aux_input_buffer_enable = aux_input_buffer_enable;
        next_pll_power_enable = pll_power_enable;
        next_mic_bias_enable = mic_bias_enable;
        next_amp_bias_enable = amp_bias_enable;
        next_reference_buffer_enable = reference_buffer_enable;
        next_reference_impedance_select = reference_impedance_select;
        next_input_boost_enable = input_boost_enable;
        next_input_gain_amp_enable = input_gain_amp_enable;
        next_converter_in_enable = converter_in_enable;
        if (wr_soft_reset) begin
            next_independent_bias_enable = `CPWR_RST_BIT;
            next_level_shifter_enable = `CPWR_RST_BIT;
            next_aux_input_buffer_enable = `CPWR_RST_BIT;
            next_pll_power_enable = `CPWR_RST_BIT;
            next_mic_bias_enable = `CPWR_RST_BIT;
            next_amp_bias_enable = `CPWR_RST_BIT;
            next_reference_buffer_enable = `CPWR_RST_BIT;
            next_reference_impedance_select = `CPWR_RST_IMP;
            next_input_boost_enable = `CPWR_RST_BIT;
            next_input_gain_amp_enable = `CPWR_RST_BIT;
            next_converter_in_enable = `CPWR_RST_BIT;
        end else if (wr_one) begin
            next_independent_bias_enable = lane_bit(independent_bias_enable,
                wr_data, wr_strb, `CPWR_P1_INDEP_BIAS);
            next_level_shifter_enable = lane_bit(level_shifter_enable,
                wr_data, wr_strb, `CPWR_P1_LEVEL_SHIFT);
            next_aux_input_buffer_enable = lane_bit(aux_input_buffer_enable,
                wr_data, wr_strb, `CPWR_P1_AUX_BUF);
            next_pll_power_enable = lane_bit(pll_power_enable,
                wr_data, wr_strb, `CPWR_P1_PLL);
            next_mic_bias_enable = lane_bit(mic_bias_enable,
                wr_data, wr_strb, `CPWR_P1_MIC_BIAS);
            next_amp_bias_enable = lane_bit(amp_bias_enable,
                wr_data, wr_strb, `CPWR_P1_AMP_BIAS);
            next_reference_buffer_enable = lane_bit(reference_buffer_enable,
                wr_data, wr_strb, `CPWR_P1_REF_BUF);
            next_reference_impedance_select[1] = lane_bit(
                reference_impedance_select[1],
                wr_data, wr_strb, `CPWR_P1_IMP_HI);
            next_reference_impedance_select[0] = lane_bit(
                reference_impedance_select[0],
                wr_data, wr_strb, `CPWR_P1_IMP_LO);
        end else if (wr_two) begin
            next_input_boost_enable = lane_bit(input_boost_enable,
                wr_data, wr_strb, `CPWR_P2_BOOST);
            next_input_gain_amp_enable = lane_bit(input_gain_amp_enable,
                wr_data, wr_strb, `CPWR_P2_GAIN_AMP);
            next_converter_in_enable = lane_bit(converter_in_enable,
                wr_data, wr_strb, `CPWR_P2_CONV_IN);
        end
        // Other bit positions are simply not stored
    end

    // Bus reset restores the same defaults as a soft reset
    always @(posedge aclk) begin
        if (!aresetn) begin
            independent_bias_enable <= `CPWR_RST_BIT;
            level_shifter_enable <= `CPWR_RST_BIT;
            aux_input_buffer_enable <= `CPWR_RST_BIT;
            pll_power_enable <= `CPWR_RST_BIT;
            mic_bias_enable <= `CPWR_RST_BIT;
            amp_bias_enable <= `CPWR_RST_BIT;
            reference_buffer_enable <= `CPWR_RST_BIT;
            reference_impedance_select <= `CPWR_RST_IMP;
            input_boost_enable <= `CPWR_RST_BIT;
            input_gain_amp_enable <= `CPWR_RST_BIT;
            converter_in_enable <= `CPWR_RST_BIT;
        end else begin
            independent_bias_enable <= next_independent_bias_enable;
            level_shifter_enable <= next_level_shifter_enable;
            aux_input_buffer_enable <= next_aux_input_buffer_enable;
            pll_power_enable <= next_pll_power_enable;
            mic_bias_enable <= next_mic_bias_enable;
            amp_bias_enable <= next_amp_bias_enable;
            reference_buffer_enable <= next_reference_buffer_enable;
            reference_impedance_select <= next_reference_impedance_select;
            input_boost_enable <= next_input_boost_enable;
            input_gain_amp_enable <= next_input_gain_amp_enable;
            converter_in_enable <= next_converter_in_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data selection

    reg [31:0] next_rdata;
    reg [1:0] next_rresp;
    reg [2:0] rd_index;

    // Unused bits stay zero in every word
    always @* begin
        rd_index = word_index(s_axi_araddr);
        next_rdata = `CPWR_ZERO_WORD;
        next_rresp = word_resp(rd_index);
        if (rd_index == {1'b1, `CPWR_IDX_RESET_ID}) begin
            next_rdata[15:0] = PART_ID;
        end else if (rd_index == {1'b1, `CPWR_IDX_POWER_ONE}) begin
            next_rdata[`CPWR_P1_INDEP_BIAS] = independent_bias_enable;
            next_rdata[`CPWR_P1_LEVEL_SHIFT] = level_shifter_enable;
            next_rdata[`CPWR_P1_AUX_BUF] = aux_input_buffer_enable;
            next_rdata[`CPWR_P1_PLL] = pll_power_enable;
            next_rdata[`CPWR_P1_MIC_BIAS] = mic_bias_enable;
            next_rdata[`CPWR_P1_AMP_BIAS] = amp_bias_enable;
            next_rdata[2:0] = REVISION;
        end else if (rd_index == {1'b1, `CPWR_IDX_POWER_TWO}) begin
            next_rdata[`CPWR_P2_BOOST] = input_boost_enable;
            next_rdata[`CPWR_P2_GAIN_AMP] = input_gain_amp_enable;
            next_rdata[`CPWR_P2_CONV_IN] = converter_in_enable;
        end else if (rd_index == {1'b1, `CPWR_IDX_STATUS}) begin
            // Reference fields hidden behind the revision readback
            next_rdata[`CPWR_P1_REF_BUF] = reference_buffer_enable;
            next_rdata[`CPWR_P1_IMP_HI] = reference_impedance_select[1];
            next_rdata[`CPWR_P1_IMP_LO] = reference_impedance_select[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel

    reg next_arready;
    reg next_rvalid;

    // Address taken when idle, answer released on rready
    always @* begin
        next_arready = s_axi_arready;
        next_rvalid = s_axi_rvalid;
        if (s_axi_arvalid && s_axi_arready) begin
            next_arready = 1'b0;
            next_rvalid = 1'b1;
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_arready = 1'b1;
            next_rvalid = 1'b0;
        end
    end

    // One read at a time, answered on the edge after the address
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `CPWR_ZERO_WORD;
            s_axi_rresp <= `CPWR_RESP_OKAY;
        end else begin
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= next_rresp;
            end
        end
    end

endmodule // cpwr_regs

// File: verif/cpwr_regs_props.sv
// Concurrent checks for the codec power register bank
`timescale 1ns/1ps
module cpwr_regs_props #(
    parameter ADDR_W = 4,
    parameter [15:0] PART_ID = 16'h0000,
    parameter [2:0] REVISION = 3'h0
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Bus handshakes
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    // Power enables
    input wire independent_bias_enable,
    input wire level_shifter_enable,
    input wire aux_input_buffer_enable,
    input wire pll_power_enable,
    input wire mic_bias_enable,
    input wire amp_bias_enable,
    input wire reference_buffer_enable,
    input wire [1:0] reference_impedance_select,
    input wire input_boost_enable,
    input wire input_gain_amp_enable,
    input wire converter_in_enable
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Taken writes and reads by word index
    wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire rd_go = s_axi_arvalid && s_axi_arready;
    wire w0 = wr_go && s_axi_awaddr[ADDR_W-1:2] == 'h0;
    wire w1 = wr_go && s_axi_awaddr[ADDR_W-1:2] == 'h1;
    wire w2l = wr_go && s_axi_awaddr[ADDR_W-1:2] == 'h2 && s_axi_wstrb[0];
    wire r0 = rd_go && s_axi_araddr[ADDR_W-1:2] == 'h0;
    wire r1 = rd_go && s_axi_araddr[ADDR_W-1:2] == 'h1;
    wire [8:0] pw = {independent_bias_enable, level_shifter_enable, aux_input_buffer_enable,
        pll_power_enable, mic_bias_enable, amp_bias_enable, reference_buffer_enable,
        reference_impedance_select};
    wire [11:0] en_all = {pw, input_boost_enable, input_gain_amp_enable, converter_in_enable};
    // Fields follow the taken word two edges later
    property p_soft_reset; w0 |-> ##2 s_axi_bvalid && en_all == 12'h000; endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset kept enables");
    property p_id_read; r0 |=> s_axi_rvalid && s_axi_rdata == {16'h0000, PART_ID}; endproperty
    a_id_read: assert property (p_id_read) else $error("identity read wrong");
    property p_rev_read;
        r1 |=> s_axi_rdata[2:0] == REVISION && s_axi_rdata[31:9] == 23'h0;
    endproperty
    a_rev_read: assert property (p_rev_read) else $error("revision read wrong");
    property p_bias; w1 && s_axi_wstrb[1] |-> ##2 pw[8] == $past(s_axi_wdata[8], 2); endproperty
    a_bias: assert property (p_bias) else $error("bias bit wrong");
    property p_low; w1 && s_axi_wstrb[0] |-> ##2 pw[7:3] == $past(s_axi_wdata[7:3], 2); endproperty
    a_low: assert property (p_low) else $error("enable bits wrong");
    property p_ref; w1 && s_axi_wstrb[0] |-> ##2 pw[2:0] == $past(s_axi_wdata[2:0], 2); endproperty
    a_ref: assert property (p_ref) else $error("reference bits wrong");
    property p_gain; w2l |-> ##2 input_gain_amp_enable == $past(s_axi_wdata[2], 2); endproperty
    a_gain: assert property (p_gain) else $error("gain amp bit wrong");
    property p_hold; $past(aresetn) && !$rose(s_axi_bvalid) |-> $stable(en_all); endproperty
    a_hold: assert property (p_hold) else $error("enables moved without a write");
    c_write: cover property (w1);
    c_read: cover property (r1);
    c_soft: cover property (w0);
endmodule // cpwr_regs_props
bind cpwr_regs cpwr_regs_props #(.ADDR_W(ADDR_W), .PART_ID(PART_ID), .REVISION(REVISION))
    cpwr_regs_props_inst (.*);

// File: verif/cpwr_host.sv
// Host controller model on the register bus
`timescale 1ns/1ps
module cpwr_host #(
    parameter ADDR_W = 4
) (
    // Clock
    input wire aclk,
    // Requests
    output reg [ADDR_W-1:0] s_axi_awaddr = 'h0,
    output reg [2:0] s_axi_awprot = 3'h0,
    output reg s_axi_awvalid = 1'b0,
    output reg [31:0] s_axi_wdata = 32'h0,
    output reg [3:0] s_axi_wstrb = 4'h0,
    output reg s_axi_wvalid = 1'b0,
    output reg s_axi_bready = 1'b0,
    output reg [ADDR_W-1:0] s_axi_araddr = 'h0,
    output reg [2:0] s_axi_arprot = 3'h0,
    output reg s_axi_arvalid = 1'b0,
    output reg s_axi_rready = 1'b0,
    // Answers
    input wire s_axi_awready,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid
);
    // One write, each channel released at its own take
    task wr(input [ADDR_W-1:0] a, input [31:0] d, input [3:0] s, output [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        while (!s_axi_bvalid) begin
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            @(posedge aclk);
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // One read, address released at its take
    task rd(input [ADDR_W-1:0] a, output [31:0] d, output [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        while (!s_axi_rvalid) begin
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            @(posedge aclk);
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule // cpwr_host

// File: verif/test_codec_power_control_regs.sv
// Self-checking bench for the codec power register bank
`timescale 1ns/1ps
`include "cpwr_map.vh"
module test_codec_power_control_regs;
    // Clock, reset, bus and enables
    reg aclk = 1'b0;
    reg aresetn = 1'b0;
    wire [4:0] s_axi_awaddr, s_axi_araddr;
    wire [2:0] s_axi_awprot, s_axi_arprot;
    wire [31:0] s_axi_wdata, s_axi_rdata;
    wire [3:0] s_axi_wstrb;
    wire [1:0] s_axi_bresp, s_axi_rresp, reference_impedance_select;
    wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    wire independent_bias_enable, level_shifter_enable, aux_input_buffer_enable;
    wire pll_power_enable, mic_bias_enable, amp_bias_enable, reference_buffer_enable;
    wire input_boost_enable, input_gain_amp_enable, converter_in_enable;
    wire [31:0] en = {18'h0, independent_bias_enable, level_shifter_enable,
        aux_input_buffer_enable, pll_power_enable, mic_bias_enable, amp_bias_enable,
        reference_buffer_enable, reference_impedance_select, input_boost_enable, 1'b0,
        input_gain_amp_enable, 1'b0, converter_in_enable};
    integer fails = 0;
    integer cmp_count = 0;
    integer cycles = 0;
    integer i;
    reg [15:0] seed = 16'hC159;
    reg [31:0] got;
    reg [1:0] rsp;
    cpwr_regs #(.ADDR_W(5)) cpwr_regs_inst (.*);
    cpwr_host #(.ADDR_W(5)) cpwr_host_inst (.*);
    always #5 aclk = ~aclk;
    // Hang guard
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails = fails + 1;
            end_of_test;
        end
    end
    function [15:0] lfsr(input [15:0] x);
        lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // Enable word expected after writing v to power_enable_one and w to power_enable_two
    function [31:0] exp_en(input [15:0] v, input [15:0] w);
        exp_en = {18'h0, v[8:0], w[4:0] & 5'h15};
    endfunction
    task chk(input string what, input [31:0] exp, input [31:0] seen);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("reset enables", 32'h0, en);
        cpwr_host_inst.rd(5'h00, got, rsp);
        chk("identity", {16'h0, `CPWR_PART_ID}, got);
        $display("test reset done");
        cpwr_host_inst.wr(5'h04, 32'h100, 4'h3, rsp);
        chk("bias first", exp_en(16'h100, 16'h0), en);
        chk("bias resp", {30'h0, `CPWR_RESP_OKAY}, {30'h0, rsp});
        for (i = 0; i < 12; i = i + 1) begin
            seed = lfsr(seed);
            cpwr_host_inst.wr(5'h04, {seed, seed}, 4'hF, rsp);
            cpwr_host_inst.wr(5'h08, {seed, ~seed}, 4'hF, rsp);
            chk("enables",
                exp_en(seed, ~seed), en);
            cpwr_host_inst.rd(5'h04, got, rsp);
            chk("power one read", {23'h0, seed[8:3], `CPWR_REVISION}, got);
            chk("power one resp", {30'h0, `CPWR_RESP_OKAY}, {30'h0, rsp});
            cpwr_host_inst.rd(5'h0C, got, rsp);
            chk("status read", {29'h0, seed[2:0]}, got);
        end
        $display("test random done");
        cpwr_host_inst.wr(5'h00, {seed, seed}, 4'h1, rsp);
        chk("soft reset", 32'h0, en);
        cpwr_host_inst.wr(5'h10, 32'h1FF, 4'hF, rsp);
        chk("unmapped resp", {30'h0, `CPWR_RESP_SLVERR}, {30'h0, rsp});
        chk("unmapped write", 32'h0, en);
        $display("test soft reset done");
        end_of_test;
    end
endmodule // test_codec_power_control_regs
